//--- hdl/cpusp_core.sv
// CPU status word, zero slot, fetch pointer and stack sequencer
`timescale 1ns/1ps
module cpusp_core
    import cpusp_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire cpusp_pkg::cpusp_req_t req,
    input  wire logic                 req_valid,
    output logic                      req_busy,
    output cpusp_pkg::cpusp_mem_t     mem,
    input  wire logic [15:0]          mem_rdata,
    output logic [16:0]               fetch_addr,
    output logic                      fault_reset,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata
);
    typedef enum logic [3:0] {
        S_IDLE, S_PUSH1, S_PUSH2, S_POP1, S_POP2, S_DONE
    } cpusp_state_t;

    logic [15:0]  cpu_status_word;
    logic [15:0]  fetch_word_pointer;
    logic [15:0]  stack_top_pointer;
    logic [15:0]  frame_base_pointer;
    cpusp_state_t state;
    cpusp_req_t   cur;

    // Zero test at operand size
    function automatic logic is_zero(input cpusp_size_t s,
                                     input logic [31:0] r);
        unique case (s)
            CPUSP_BYTE: is_zero = (r[7:0] == 8'h00);
            CPUSP_WORD: is_zero = (r[15:0] == 16'h0000);
            default:    is_zero = (r == 32'h0000_0000);
        endcase
    endfunction : is_zero

    // Sign bit at operand size
    function automatic logic top_bit(input cpusp_size_t s,
                                     input logic [31:0] r);
        unique case (s)
            CPUSP_BYTE: top_bit = r[7];
            CPUSP_WORD: top_bit = r[15];
            default:    top_bit = r[31];
        endcase
    endfunction : top_bit

    logic [15:0] sp_minus;
    logic [15:0] ret_ptr;
    assign sp_minus = stack_top_pointer - WORD_STEP;
    assign ret_ptr  = mem_rdata - WORD_STEP;

    // Pointer loads only hit their own offsets, so other writes lose nothing
    logic ptr_wr;
    assign ptr_wr = reg_wr && state == S_IDLE
                    && (reg_addr == OFS_STACK || reg_addr == OFS_FRAME
                        || reg_addr == OFS_FETCH);

    // Status word: flags, level and context restore
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cpu_status_word <= ST_RESET;
        end else if (reg_wr && reg_addr == OFS_STATUS) begin
            cpu_status_word <= reg_wdata[15:0] & ST_KEEP_MASK;
        end else if (state == S_IDLE && req_valid) begin
            unique case (req.op)
                CPUSP_ALU: begin
                    cpu_status_word[ST_Z_BIT] <= is_zero(req.size,
                                                         req.result);
                    cpu_status_word[ST_N_BIT] <= top_bit(req.size,
                                                         req.result);
                    cpu_status_word[ST_C_BIT] <= req.carry;
                    cpu_status_word[ST_V_BIT] <= req.ovf;
                end
                CPUSP_SHIFT: cpu_status_word[ST_C_BIT] <= req.carry;
                CPUSP_BITLD: cpu_status_word[ST_C_BIT] <= req.bit_in;
                default: ;
            endcase
        end else if (state == S_PUSH1 && cur.op == CPUSP_TRAP) begin
            // mask to all ones; three-bit level
            cpu_status_word[ST_LVL_LO +: 3] <= LVL_ALL;
        end else if (state == S_POP2 && cur.op == CPUSP_RETI) begin
            cpu_status_word <= mem_rdata & ST_KEEP_MASK;
        end
    end

    // Context sequencer for stack traffic
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= S_IDLE;
            cur   <= '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (req_valid) begin
                        cur <= req;
                        unique case (req.op)
                            CPUSP_CALL, CPUSP_LINK: state <= S_PUSH2;
                            CPUSP_TRAP, CPUSP_ILLEGAL,
                            CPUSP_IRQ: state <= S_PUSH1;
                            CPUSP_RET, CPUSP_RETI,
                            CPUSP_UNLINK: state <= S_POP1;
                            default: state <= S_IDLE;
                        endcase
                    end
                end
                S_PUSH1: state <= S_PUSH2;
                S_PUSH2: state <= S_DONE;
                S_POP1: state <= (cur.op == CPUSP_RETI) ? S_POP2 : S_DONE;
                S_POP2: state <= S_DONE;
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Stack, frame and fetch pointers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stack_top_pointer  <= PTR_RESET;
            frame_base_pointer <= PTR_RESET;
            fetch_word_pointer <= PTR_RESET;
        end else if (ptr_wr) begin
            // Software loads only between sequences
            if (reg_addr == OFS_STACK)
                stack_top_pointer <= reg_wdata[15:0];
            if (reg_addr == OFS_FRAME)
                frame_base_pointer <= reg_wdata[15:0];
            if (reg_addr == OFS_FETCH)
                fetch_word_pointer <= reg_wdata[15:0];
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (req_valid && req.op == CPUSP_ADVANCE)
                        // one to three words; lead kept
                        fetch_word_pointer <= fetch_word_pointer
                                              + {14'h0000, req.words};
                    else if (req_valid && req.op == CPUSP_JUMP)
                        fetch_word_pointer <= req.target;
                    // frame copied into stack before the pop
                    else if (req_valid && req.op == CPUSP_UNLINK)
                        stack_top_pointer <= frame_base_pointer;
                end
                S_PUSH1, S_PUSH2: begin
                    stack_top_pointer <= stack_top_pointer + WORD_STEP;
                end
                S_POP1, S_POP2: begin
                    stack_top_pointer <= sp_minus;
                end
                S_DONE: begin
                    unique case (cur.op)
                        CPUSP_CALL: fetch_word_pointer <= cur.target;
                        // frame takes pushed top; displacement added
                        CPUSP_LINK: begin
                            frame_base_pointer <= stack_top_pointer;
                            stack_top_pointer  <= stack_top_pointer
                                                  + cur.disp;
                        end
                        CPUSP_TRAP: fetch_word_pointer <= VEC_BASE_W
                                          + {8'h00, cur.vector};
                        CPUSP_ILLEGAL: fetch_word_pointer <= VEC_BASE_W;
                        CPUSP_IRQ: fetch_word_pointer <= cur.target;
                        default: ;
                    endcase
                end
                default: ;
            endcase
            if (state == S_POP1) begin
                unique case (cur.op)
                    CPUSP_RET: fetch_word_pointer <= mem_rdata;
                    CPUSP_RETI: fetch_word_pointer <= ret_ptr;
                    CPUSP_UNLINK: frame_base_pointer <= mem_rdata;
                    default: ;
                endcase
            end
        end
    end

    // Memory request: pops read combinationally at the lowered pointer
    always_comb begin
        mem = '0;
        unique case (state)
            S_PUSH1: begin
                mem.wr    = 1'b1;
                mem.addr  = {1'b0, stack_top_pointer};
                mem.wdata = cpu_status_word;
            end
            S_PUSH2: begin
                mem.wr    = 1'b1;
                mem.addr  = {1'b0, stack_top_pointer};
                mem.wdata = (cur.op == CPUSP_LINK) ? frame_base_pointer
                                                   : fetch_word_pointer;
            end
            S_POP1, S_POP2: begin
                mem.rd   = 1'b1;
                mem.addr = {1'b0, sp_minus};
            end
            default: ;
        endcase
    end

    // fetch byte address, bit 0 forced low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            fetch_addr <= 17'h00000;
        else
            fetch_addr <= {fetch_word_pointer, 1'b0};
    end

    // odd stack address requests a device reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            fault_reset <= 1'b0;
        else
            fault_reset <= (mem.rd || mem.wr) && mem.addr[0];
    end

    // Requests that run a stack sequence
    function automatic logic starts_seq(input cpusp_op_t o);
        unique case (o)
            CPUSP_CALL, CPUSP_LINK, CPUSP_TRAP, CPUSP_ILLEGAL,
            CPUSP_IRQ, CPUSP_RET, CPUSP_RETI, CPUSP_UNLINK:
                starts_seq = 1'b1;
            default: starts_seq = 1'b0;
        endcase
    endfunction : starts_seq

    // Busy kept as its own flop so the output carries no decode glitch
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            req_busy <= 1'b0;
        else if (state == S_IDLE && req_valid)
            req_busy <= starts_seq(req.op);
        else if (state == S_DONE)
            req_busy <= 1'b0;
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFS_STATUS: reg_rdata <= {16'h0000, cpu_status_word};
                OFS_FETCH:  reg_rdata <= {16'h0000, fetch_word_pointer};
                OFS_STACK:  reg_rdata <= {16'h0000, stack_top_pointer};
                OFS_FRAME:  reg_rdata <= {16'h0000, frame_base_pointer};
                OFS_FAULT:  reg_rdata <= {31'h0, fault_reset};
                default:    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Assertions
    property p_zero_flag;
        @(posedge mclk) disable iff (!rstn)
        (state == S_IDLE && req_valid && req.op == CPUSP_ALU && !reg_wr)
        |=> cpu_status_word[ST_Z_BIT] == is_zero($past(req.size),
                                                 $past(req.result));
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag wrong");

    property p_neg_flag;
        @(posedge mclk) disable iff (!rstn)
        (state == S_IDLE && req_valid && req.op == CPUSP_ALU && !reg_wr)
        |=> cpu_status_word[ST_N_BIT] == top_bit($past(req.size),
                                                 $past(req.result));
    endproperty
    a_neg_flag: assert property (p_neg_flag)
        else $error("negative flag wrong");

    property p_reserved;
        @(posedge mclk) disable iff (!rstn)
        (cpu_status_word & ~ST_KEEP_MASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bit held data");

    property p_zero_slot;
        @(posedge mclk) disable iff (!rstn)
        (reg_rd && reg_addr == OFS_ZERO) |=> reg_rdata == 32'h0;
    endproperty
    a_zero_slot: assert property (p_zero_slot)
        else $error("zero slot read nonzero");

    property p_fetch_addr;
        @(posedge mclk) disable iff (!rstn)
        ##1 fetch_addr == {$past(fetch_word_pointer), 1'b0};
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("fetch address mismatch");

    property p_push_step;
        @(posedge mclk) disable iff (!rstn)
        (state == S_PUSH2 && !reg_wr)
        |=> stack_top_pointer == $past(stack_top_pointer) + WORD_STEP;
    endproperty
    a_push_step: assert property (p_push_step)
        else $error("push did not add two");

    property p_irq_order;
        @(posedge mclk) disable iff (!rstn)
        (state == S_PUSH1) |-> mem.wr && mem.wdata == cpu_status_word
                               ##1 state == S_PUSH2 && mem.wr
                               && mem.addr == $past(mem.addr) + 17'h00002;
    endproperty
    a_irq_order: assert property (p_irq_order)
        else $error("context push order wrong");

    property p_trap_level;
        @(posedge mclk) disable iff (!rstn)
        (state == S_PUSH1 && cur.op == CPUSP_TRAP && !reg_wr)
        |=> cpu_status_word[ST_LVL_LO +: 3] == LVL_ALL;
    endproperty
    a_trap_level: assert property (p_trap_level)
        else $error("trap did not raise level");

    property p_odd_fault;
        @(posedge mclk) disable iff (!rstn)
        ((mem.rd || mem.wr) && mem.addr[0]) |=> fault_reset;
    endproperty
    a_odd_fault: assert property (p_odd_fault)
        else $error("odd access not faulted");

    c_call: cover property (@(posedge mclk) disable iff (!rstn)
        state == S_DONE && cur.op == CPUSP_CALL);
    c_reti: cover property (@(posedge mclk) disable iff (!rstn)
        state == S_POP2);
    c_trap: cover property (@(posedge mclk) disable iff (!rstn)
        state == S_DONE && cur.op == CPUSP_TRAP);
endmodule : cpusp_core

//--- inc/cpusp_pkg.sv
// Package for the CPU status, fetch pointer and stack block
package cpusp_pkg;
    // Register bus offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_FETCH    = 8'h04;
    localparam logic [7:0] OFS_STACK    = 8'h08;
    localparam logic [7:0] OFS_FRAME    = 8'h0c;
    localparam logic [7:0] OFS_ZERO     = 8'h10;
    localparam logic [7:0] OFS_FAULT    = 8'h14;
    // Status word field positions
    localparam int         ST_C_BIT     = 0;
    localparam int         ST_V_BIT     = 1;
    localparam int         ST_N_BIT     = 2;
    localparam int         ST_Z_BIT     = 3;
    localparam int         ST_LVL_LO    = 8;
    localparam logic [15:0] ST_KEEP_MASK = 16'h070f;
    localparam logic [15:0] ST_RESET    = 16'h0000;
    localparam logic [15:0] PTR_RESET   = 16'h0000;
    localparam logic [2:0]  LVL_ALL     = 3'h7;
    // Trap vector table base, as a word address (byte 08000h)
    localparam logic [15:0] VEC_BASE_W  = 16'h4000;
    localparam logic [15:0] WORD_STEP   = 16'h0002;

    typedef enum logic [1:0] {
        CPUSP_BYTE,
        CPUSP_WORD,
        CPUSP_LONG
    } cpusp_size_t;

    typedef enum logic [3:0] {
        CPUSP_NONE,
        CPUSP_ALU,
        CPUSP_SHIFT,
        CPUSP_BITLD,
        CPUSP_JUMP,
        CPUSP_CALL,
        CPUSP_RET,
        CPUSP_RETI,
        CPUSP_LINK,
        CPUSP_UNLINK,
        CPUSP_TRAP,
        CPUSP_ILLEGAL,
        CPUSP_IRQ,
        CPUSP_ADVANCE
    } cpusp_op_t;

    // One request from the sequencer
    typedef struct packed {
        cpusp_op_t   op;
        cpusp_size_t size;
        logic [31:0] result;
        logic        carry;
        logic        ovf;
        logic        bit_in;
        logic [15:0] target;
        logic [15:0] disp;
        logic [7:0]  vector;
        logic [1:0]  words;
    } cpusp_req_t;

    // Memory bus request towards RAM and program memory
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [16:0] addr;
        logic [15:0] wdata;
    } cpusp_mem_t;
endpackage : cpusp_pkg

//--- testbench/cpusp_mem_model.sv
// Zero-wait word memory on the far side of the stack bus
`timescale 1ns/1ps
module cpusp_mem_model
    import cpusp_pkg::*;
(
    input  wire logic                  mclk,
    input  wire cpusp_pkg::cpusp_mem_t mem,
    output logic [15:0]                mem_rdata
);
    logic [15:0] ram [0:32767];
    logic [15:0] last = 16'h0000;
    logic [16:0] last_waddr;
    always_ff @(posedge mclk) begin
        if (mem.wr) begin
            ram[mem.addr[15:1]] <= mem.wdata;
            last_waddr          <= mem.addr;
        end
    end
    // Remember the last read so an idle bus can show its inverse
    always_ff @(posedge mclk) begin
        if (mem.rd) begin
            last <= ram[mem.addr[15:1]];
        end
    end
    // same-cycle read
    // Idle bus never repeats stale data, so late sampling is caught
    assign mem_rdata = mem.rd ? ram[mem.addr[15:1]] : ~last;
endmodule : cpusp_mem_model

//--- testbench/test_cpusp_core.sv
// Self-checking bench for the status, fetch pointer and stack block
`timescale 1ns/1ps
module test_cpusp_core;
    import cpusp_pkg::*;
    logic        mclk;
    logic        rstn;
    cpusp_req_t  req;
    logic        req_valid;
    logic        req_busy;
    cpusp_mem_t  mem;
    logic [15:0] mem_rdata;
    logic [16:0] fetch_addr;
    logic        fault_reset;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;

    cpusp_core dut (.mclk(mclk), .rstn(rstn), .req(req),
        .req_valid(req_valid), .req_busy(req_busy), .mem(mem),
        .mem_rdata(mem_rdata), .fetch_addr(fetch_addr),
        .fault_reset(fault_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    cpusp_mem_model mm (.mclk(mclk), .mem(mem), .mem_rdata(mem_rdata));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic chkreg(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk(n, reg_rdata, e);
    endtask : chkreg

    // Issue one request, then wait for the sequence to finish
    task automatic go(input cpusp_req_t r);
        @(posedge mclk);
        req       <= r;
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        #1;
        for (int i = 0; i < 8 && req_busy !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        chk("busy", {31'h0, req_busy}, 32'h0);
    endtask : go

    task automatic setp(input logic [15:0] st, fp, sp, fr);
        wr(OFS_STATUS, {16'h0, st});
        wr(OFS_FETCH, {16'h0, fp});
        wr(OFS_STACK, {16'h0, sp});
        wr(OFS_FRAME, {16'h0, fr});
    endtask : setp

    task automatic flag(input cpusp_op_t op, input cpusp_size_t sz,
                        input logic [31:0] res, input logic [2:0] cvb,
                        input logic [15:0] m, e);
        cpusp_req_t r;
        r = '0;
        r.op = op;
        r.size = sz;
        r.result = res;
        {r.carry, r.ovf, r.bit_in} = cvb;
        go(r);
        @(posedge mclk);
        reg_addr <= OFS_STATUS;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk("flags", reg_rdata & {16'h0, m}, {16'h0, e});
    endtask : flag

    task automatic t_reset;
        chkreg("status", OFS_STATUS, 32'h0);
        chkreg("fetch", OFS_FETCH, 32'h0);
        chkreg("stack", OFS_STACK, 32'h0);
        chkreg("frame", OFS_FRAME, 32'h0);
        chkreg("unmapped", 8'h40, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_flags;
        flag(CPUSP_ALU, CPUSP_BYTE, 32'h100, 3'b100, 16'hf, 16'h9);
        flag(CPUSP_ALU, CPUSP_BYTE, 32'h080, 3'b010, 16'hf, 16'h6);
        flag(CPUSP_ALU, CPUSP_WORD, 32'h10000, 3'b000, 16'hf, 16'h8);
        flag(CPUSP_ALU, CPUSP_WORD, 32'h8000, 3'b110, 16'hf, 16'h7);
        flag(CPUSP_ALU, CPUSP_LONG, 32'h80000000, 3'b0, 16'hf, 16'h4);
        flag(CPUSP_ALU, CPUSP_LONG, 32'h0, 3'b010, 16'hf, 16'ha);
        flag(CPUSP_SHIFT, CPUSP_WORD, 32'h2, 3'b100, 16'h1, 16'h1);
        flag(CPUSP_BITLD, CPUSP_WORD, 32'h2, 3'b100, 16'h1, 16'h0);
        flag(CPUSP_BITLD, CPUSP_WORD, 32'h2, 3'b001, 16'h1, 16'h1);
        $display("flag test done");
    endtask : t_flags

    task automatic t_regs;
        wr(OFS_STATUS, 32'hffffffff);
        chkreg("status", OFS_STATUS, 32'h070f);
        wr(OFS_ZERO, 32'h1234);
        chkreg("zero", OFS_ZERO, 32'h0);
        wr(OFS_FETCH, 32'h1ffff);
        chkreg("fetch", OFS_FETCH, 32'hffff);
        chk("fetch_addr", {15'h0, fetch_addr}, 32'h1fffe);
        $display("register test done");
    endtask : t_regs

    task automatic t_advance;
        cpusp_req_t r;
        logic [15:0] p;
        p = 16'h0010;
        wr(OFS_FETCH, {16'h0, p});
        for (int w = 1; w <= 3; w++) begin
            r = '0;
            r.op = CPUSP_ADVANCE;
            r.words = w[1:0];
            go(r);
            p = p + 16'(w);
            chkreg("fetch", OFS_FETCH, {16'h0, p});
        end
        r = '0;
        r.op = CPUSP_JUMP;
        r.target = 16'h8123;
        go(r);
        chkreg("fetch", OFS_FETCH, 32'h8123);
        chk("fetch_addr", {15'h0, fetch_addr}, 32'h10246);
        $display("advance test done");
    endtask : t_advance

    task automatic t_call_ret;
        cpusp_req_t r;
        setp(16'h0, 16'h0052, 16'h0100, 16'h0);
        r = '0;
        r.op = CPUSP_CALL;
        r.target = 16'hc000;
        go(r);
        chkreg("stack", OFS_STACK, 32'h0102);
        chkreg("fetch", OFS_FETCH, 32'hc000);
        chk("push addr", {15'h0, mm.last_waddr}, 32'h0100);
        chk("push pc", {16'h0, mm.ram[16'h0080]}, 32'h0052);
        chk("fetch_addr", {15'h0, fetch_addr}, 32'h18000);
        r.op = CPUSP_RET;
        go(r);
        chkreg("fetch", OFS_FETCH, 32'h0052);
        chkreg("stack", OFS_STACK, 32'h0100);
        $display("call test done");
    endtask : t_call_ret

    task automatic t_irq;
        cpusp_req_t r;
        setp(16'h0305, 16'h0040, 16'h0200, 16'h0);
        r = '0;
        r.op = CPUSP_IRQ;
        r.target = 16'h0900;
        go(r);
        chk("push st", {16'h0, mm.ram[16'h0100]}, 32'h0305);
        chk("push pc", {16'h0, mm.ram[16'h0101]}, 32'h0040);
        chkreg("stack", OFS_STACK, 32'h0204);
        chkreg("fetch", OFS_FETCH, 32'h0900);
        wr(OFS_STATUS, 32'h0);
        r.op = CPUSP_RETI;
        go(r);
        chkreg("fetch", OFS_FETCH, 32'h003e);
        chkreg("status", OFS_STATUS, 32'h0305);
        chkreg("stack", OFS_STACK, 32'h0200);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_trap;
        cpusp_req_t r;
        setp(16'h0001, 16'h0070, 16'h0300, 16'h0);
        r = '0;
        r.op = CPUSP_TRAP;
        r.vector = 8'h05;
        go(r);
        chk("push st", {16'h0, mm.ram[16'h0180]}, 32'h0001);
        chk("push pc", {16'h0, mm.ram[16'h0181]}, 32'h0070);
        chkreg("fetch", OFS_FETCH, 32'h4005);
        chkreg("status", OFS_STATUS, 32'h0701);
        r.op = CPUSP_ILLEGAL;
        go(r);
        chkreg("fetch", OFS_FETCH, 32'h4000);
        chkreg("stack", OFS_STACK, 32'h0308);
        $display("trap test done");
    endtask : t_trap

    task automatic t_frame;
        cpusp_req_t r;
        setp(16'h0, 16'h0, 16'h0310, 16'h0abc);
        r = '0;
        r.op = CPUSP_LINK;
        r.disp = 16'h0010;
        go(r);
        chk("push fp", {16'h0, mm.ram[16'h0188]}, 32'h0abc);
        chkreg("frame", OFS_FRAME, 32'h0312);
        chkreg("stack", OFS_STACK, 32'h0322);
        r.op = CPUSP_UNLINK;
        go(r);
        chkreg("frame", OFS_FRAME, 32'h0abc);
        chkreg("stack", OFS_STACK, 32'h0310);
        $display("frame test done");
    endtask : t_frame

    // Odd stack pointer must end in a reset request, then reset again
    task automatic t_fault;
        cpusp_req_t r;
        logic seen;
        seen = 1'b0;
        wr(OFS_STACK, 32'h0101);
        r = '0;
        r.op = CPUSP_CALL;
        @(posedge mclk);
        req       <= r;
        req_valid <= 1'b1;
        @(posedge mclk);
        req_valid <= 1'b0;
        repeat (8) begin
            #1;
            seen = seen | (fault_reset === 1'b1);
            @(posedge mclk);
        end
        chk("fault", {31'h0, seen}, 32'h1);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        chkreg("stack", OFS_STACK, 32'h0);
        $display("fault test done");
    endtask : t_fault

    initial begin
        rstn      = 1'b0;
        req       = '0;
        req_valid = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        t_reset;
        t_flags;
        t_regs;
        t_advance;
        t_call_ret;
        t_irq;
        t_trap;
        t_frame;
        t_fault;
        report_and_stop;
    end
endmodule : test_cpusp_core
